// ---- pkg/mawf_consts.svh ----
/*
 * offsets, field positions, reset values and widths of the monitor
 * alarm and warning flag bank.
 * assumes: included by bare name from package and design files.
 */
`ifndef MAWF_CONSTS_SVH
`define MAWF_CONSTS_SVH
`define MAWF_ADDR_W 8
`define MAWF_DATA_W 8
`define MAWF_MEAS_W 16
`define MAWF_OFS_FAST_ALARM 8'h73
`define MAWF_OFS_WARN_MAIN 8'h74
`define MAWF_OFS_WARN_AUX 8'h75
`define MAWF_OFS_RSVD_FIRST 8'h76
`define MAWF_OFS_RSVD_LAST 8'h7A
`define MAWF_RST_FAST_ALARM 8'h00
`define MAWF_RST_WARN_MAIN 8'h10
`define MAWF_RST_WARN_AUX 8'h00
`define MAWF_RSVD_VALUE 8'h00
`define MAWF_BIT_M3_FAST_HI 7
`define MAWF_BIT_M3_FAST_LO 6
`define MAWF_BIT_BIAS_CEIL 3
`define MAWF_BIT_TEMPERATURE_HIGH_FLAG 7
`define MAWF_BIT_TEMPERATURE_LOW_FLAG 6
`define MAWF_BIT_SUP_HI 5
`define MAWF_BIT_SUP_LO 4
`define MAWF_BIT_M1_HI 3
`define MAWF_BIT_M1_LO 2
`define MAWF_BIT_M2_HI 1
`define MAWF_BIT_M2_LO 0
`define MAWF_BIT_M3_HI 7
`define MAWF_BIT_M3_LO 6
`define MAWF_BIT_M4_HI 5
`define MAWF_BIT_M4_LO 4
`define MAWF_SYNC_STAGES 3
`endif

// ---- pkg/mawf_pkg.sv ----
/*
 * types of the monitor alarm and warning flag bank.
 * assumes: mawf_consts.svh is on the include path.
 */
`include "mawf_consts.svh"
package mawf_pkg;
    typedef logic [`MAWF_DATA_W-1:0] mawf_byte_t;
    typedef logic [`MAWF_MEAS_W-1:0] mawf_meas_t;
    // one warning channel: high flag and low flag
    typedef struct packed {
        logic high;
        logic low;
    } mawf_pair_t;
endpackage

// ---- core/mawf_window_cmp.sv ----
/*
 * one warning channel: compares a completed measurement against a high
 * and a low threshold and holds both flags until the next completion, except that force_low sets the low flag in any cycle.
 * assumes: inputs on the same clock; done is a one-cycle pulse.
 */
`timescale 1ns/1ps
`include "mawf_consts.svh"
module mawf_window_cmp #(
    parameter logic RST_LOW = 1'b0
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire mawf_pkg::mawf_meas_t meas,
    input wire mawf_pkg::mawf_meas_t thr_high,
    input wire mawf_pkg::mawf_meas_t thr_low,
    input wire logic done,
    input wire logic force_low,
    output mawf_pkg::mawf_pair_t flags
);
    typedef struct packed {
        mawf_pkg::mawf_pair_t pair;
    } mawf_cmp_state_t;

    mawf_cmp_state_t st_q;
    mawf_cmp_state_t st_d;

    always_comb begin
        st_d = st_q;
        if (done) begin
            st_d.pair.high = meas > thr_high;
            st_d.pair.low = meas < thr_low;
        end
        if (force_low) begin
            st_d.pair.low = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '{pair: '{high: 1'b0, low: RST_LOW}};
        end else begin
            st_q <= st_d;
        end
    end

    assign flags = st_q.pair;

    a_high_follows: assert property (
        @(posedge clk) disable iff (sys_rst)
        done |=> flags.high == ($past(meas) > $past(thr_high)))
        else $error("high warning does not track measurement");
endmodule

// ---- core/mawf_flag_bank.sv ----
/*
 * monitor alarm and warning flag bank: fast alarms, bias ceiling alarm
 * and the two warning registers, read through the serial memory map.
 * assumes: measurement engine supplies values with one-cycle done
 * pulses on clk; serial slave gives a same-clock read address and a
 * write strobe; the supply trip comparator is an asynchronous pin.
 */
`timescale 1ns/1ps
`include "mawf_consts.svh"
// Overview of operation
// - the monitor-three fast high alarm follows the latest fast comparison being above threshold and ignores transmit disable.
// - the monitor-three fast low alarm follows the latest fast comparison being below threshold and ignores transmit disable.
// - the bias ceiling alarm is high while requested bias exceeds the ceiling limit and is cleared by transmit disable.
// - high warnings for temperature, supply, monitor one and two set when the last measurement is above the high threshold.
// - low warnings for the same four channels set when the last measurement is below the low threshold.
// - the supply low warning powers up set, is held set below the trip point, and clears on a measurement above the low threshold.
// - the auxiliary warning register holds monitor three and four warnings in bits 7 to 4 with bits 3 to 0 zero.
// - addresses 76h to 7Ah read 00h and ignore writes.
module mawf_flag_bank (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [`MAWF_ADDR_W-1:0] rd_addr,
    output mawf_pkg::mawf_byte_t rd_data,
    output logic rd_hit,
    input wire logic wr_en,
    input wire logic [`MAWF_ADDR_W-1:0] wr_addr,
    input wire mawf_pkg::mawf_byte_t wr_data,
    input wire logic fast_cmp_done,
    input wire logic fast_above,
    input wire logic fast_below,
    input wire logic [8:0] bias_request,
    input wire logic [8:0] bias_ceiling_limit,
    input wire logic tx_disable_event,
    input wire logic power_on_analog_trip,
    input wire mawf_pkg::mawf_meas_t meas_value [6],
    input wire mawf_pkg::mawf_meas_t thr_high [6],
    input wire mawf_pkg::mawf_meas_t thr_low [6],
    input wire logic [5:0] meas_done
);
    typedef struct packed {
        logic m3_fast_hi;
        logic m3_fast_lo;
        logic bias_ceil;
        logic [2:0] trip_sync;
        logic below_trip;
        mawf_pkg::mawf_byte_t rd_data;
        logic rd_hit;
    } mawf_state_t;

    mawf_state_t st_q;
    mawf_state_t st_d;
    mawf_pkg::mawf_pair_t chan [6];
    mawf_pkg::mawf_byte_t fast_alarm_status;
    mawf_pkg::mawf_byte_t warning_status_main;
    mawf_pkg::mawf_byte_t warning_status_aux;

    // channels: 0 temperature, 1 supply, 2..5 monitor one..four
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_chan
            mawf_window_cmp #(
                .RST_LOW((gi == 1) ? 1'b1 : 1'b0)
            ) u_cmp (
                .clk(clk),
                .sys_rst(sys_rst),
                .meas(meas_value[gi]),
                .thr_high(thr_high[gi]),
                .thr_low(thr_low[gi]),
                .done(meas_done[gi]),
                .force_low((gi == 1) ? st_q.below_trip : 1'b0),
                .flags(chan[gi])
            );
        end
    endgenerate

    always_comb begin
        fast_alarm_status = `MAWF_RST_FAST_ALARM;
        fast_alarm_status[`MAWF_BIT_M3_FAST_HI] = st_q.m3_fast_hi;
        fast_alarm_status[`MAWF_BIT_M3_FAST_LO] = st_q.m3_fast_lo;
        fast_alarm_status[`MAWF_BIT_BIAS_CEIL] = st_q.bias_ceil;
        warning_status_main = {chan[0].high, chan[0].low,
                               chan[1].high, chan[1].low,
                               chan[2].high, chan[2].low,
                               chan[3].high, chan[3].low};
        warning_status_aux = `MAWF_RST_WARN_AUX;
        warning_status_aux[`MAWF_BIT_M3_HI] = chan[4].high;
        warning_status_aux[`MAWF_BIT_M3_LO] = chan[4].low;
        warning_status_aux[`MAWF_BIT_M4_HI] = chan[5].high;
        warning_status_aux[`MAWF_BIT_M4_LO] = chan[5].low;
    end

    always_comb begin
        st_d = st_q;
        // trip pin: three stages, change accepted when last two agree
        st_d.trip_sync = {st_q.trip_sync[1:0], power_on_analog_trip};
        if (st_q.trip_sync[2] == st_q.trip_sync[1]) begin
            st_d.below_trip = st_q.trip_sync[2];
        end
        if (fast_cmp_done) begin
            st_d.m3_fast_hi = fast_above;
            st_d.m3_fast_lo = fast_below;
        end
        // transmit disable clears only the bias ceiling alarm
        if (tx_disable_event) begin
            st_d.bias_ceil = 1'b0;
        end else begin
            st_d.bias_ceil = bias_request > bias_ceiling_limit;
        end
        // writes are never decoded: flags stay comparison-owned
        st_d.rd_hit = 1'b1;
        unique case (rd_addr)
            `MAWF_OFS_FAST_ALARM: st_d.rd_data = fast_alarm_status;
            `MAWF_OFS_WARN_MAIN: st_d.rd_data = warning_status_main;
            `MAWF_OFS_WARN_AUX: st_d.rd_data = warning_status_aux;
            default: begin
                st_d.rd_data = `MAWF_RSVD_VALUE;
                st_d.rd_hit = (rd_addr >= `MAWF_OFS_RSVD_FIRST) &&
                              (rd_addr <= `MAWF_OFS_RSVD_LAST);
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '{m3_fast_hi: 1'b0, m3_fast_lo: 1'b0, bias_ceil: 1'b0,
                      trip_sync: 3'h0, below_trip: 1'b0,
                      rd_data: 8'h00, rd_hit: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign rd_data = st_q.rd_data;
    assign rd_hit = st_q.rd_hit;

    a_fast_hi_follow: assert property (
        @(posedge clk) disable iff (sys_rst)
        fast_cmp_done |=> st_q.m3_fast_hi == $past(fast_above))
        else $error("fast high alarm does not follow comparison");
    a_fast_lo_hold: assert property (
        @(posedge clk) disable iff (sys_rst)
        (!fast_cmp_done && tx_disable_event) |=> $stable(st_q.m3_fast_lo))
        else $error("fast low alarm changed on transmit disable");
    a_bias_ceil_set: assert property (
        @(posedge clk) disable iff (sys_rst)
        (!tx_disable_event && bias_request > bias_ceiling_limit)
        |=> fast_alarm_status[3])
        else $error("bias ceiling alarm missing");
    a_bias_txd_clear: assert property (
        @(posedge clk) disable iff (sys_rst)
        tx_disable_event |=> !fast_alarm_status[3])
        else $error("bias ceiling alarm not cleared");
    a_low_warn_track: assert property (
        @(posedge clk) disable iff (sys_rst)
        meas_done[0] |=> chan[0].low == ($past(meas_value[0]) <
                                         $past(thr_low[0])))
        else $error("temperature low warning wrong");
    a_supply_trip: assert property (
        @(posedge clk) disable iff (sys_rst)
        st_q.below_trip |=> warning_status_main[4])
        else $error("supply low warning clear below trip");
    a_aux_rsvd_zero: assert property (
        @(posedge clk) disable iff (sys_rst)
        (rd_addr == 8'h75) |=> rd_data[3:0] == 4'h0)
        else $error("aux reserved bits nonzero");
    a_rsvd_read: assert property (
        @(posedge clk) disable iff (sys_rst)
        (rd_addr >= 8'h76 && rd_addr <= 8'h7A) |=> rd_data == 8'h00 && rd_hit)
        else $error("reserved range read nonzero");
    a_write_ignored: assert property (
        @(posedge clk) disable iff (sys_rst)
        (wr_en && !fast_cmp_done && !meas_done[0]) |=> $stable(st_q.m3_fast_hi)
        && $stable(chan[0]))
        else $error("host write altered a flag");

    a_fast_lo_follow: assert property (
        @(posedge clk) disable iff (sys_rst)
        fast_cmp_done |=> st_q.m3_fast_lo == $past(fast_below))
        else $error("fast low alarm does not follow comparison");
    a_fast_hi_hold: assert property (
        @(posedge clk) disable iff (sys_rst)
        (!fast_cmp_done && tx_disable_event) |=> $stable(st_q.m3_fast_hi))
        else $error("fast high alarm changed on transmit disable");
    a_fast_hi_idle: assert property (
        @(posedge clk) disable iff (sys_rst)
        !fast_cmp_done |=> $stable(st_q.m3_fast_hi))
        else $error("fast high alarm moved without comparison");
    a_fast_lo_idle: assert property (
        @(posedge clk) disable iff (sys_rst)
        !fast_cmp_done |=> $stable(st_q.m3_fast_lo))
        else $error("fast low alarm moved without comparison");
    a_bias_ceil_low: assert property (
        @(posedge clk) disable iff (sys_rst)
        (bias_request <= bias_ceiling_limit) |=> !st_q.bias_ceil)
        else $error("bias ceiling alarm set at or under limit");
    a_bias_follow: assert property (
        @(posedge clk) disable iff (sys_rst)
        !tx_disable_event |=> st_q.bias_ceil ==
            ($past(bias_request) > $past(bias_ceiling_limit)))
        else $error("bias ceiling alarm does not follow request");
    a_fast_rsvd_zero: assert property (
        @(posedge clk) disable iff (sys_rst)
        fast_alarm_status[5:4] == 2'h0 && fast_alarm_status[2:0] == 3'h0)
        else $error("fast alarm reserved bits nonzero");
    a_temp_high: assert property (
        @(posedge clk) disable iff (sys_rst)
        meas_done[0] |=> chan[0].high == ($past(meas_value[0]) >
            $past(thr_high[0])))
        else $error("temperature high warning wrong");
    a_supply_high: assert property (
        @(posedge clk) disable iff (sys_rst)
        meas_done[1] |=> chan[1].high == ($past(meas_value[1]) >
            $past(thr_high[1])))
        else $error("supply high warning wrong");
    a_monitor_input_one_high: assert property (
        @(posedge clk) disable iff (sys_rst)
        meas_done[2] |=> chan[2].high == ($past(meas_value[2]) >
            $past(thr_high[2])))
        else $error("monitor one high warning wrong");
    a_monitor_input_two_high: assert property (
        @(posedge clk) disable iff (sys_rst)
        meas_done[3] |=> chan[3].high == ($past(meas_value[3]) >
            $past(thr_high[3])))
        else $error("monitor two high warning wrong");
    a_monitor_input_three_high: assert property (
        @(posedge clk) disable iff (sys_rst)
        meas_done[4] |=> chan[4].high == ($past(meas_value[4]) >
            $past(thr_high[4])))
        else $error("monitor three high warning wrong");
    a_monitor_input_four_high: assert property (
        @(posedge clk) disable iff (sys_rst)
        meas_done[5] |=> chan[5].high == ($past(meas_value[5]) >
            $past(thr_high[5])))
        else $error("monitor four high warning wrong");
    a_supply_low: assert property (
        @(posedge clk) disable iff (sys_rst)
        (meas_done[1] && !st_q.below_trip) |=> chan[1].low ==
            ($past(meas_value[1]) < $past(thr_low[1])))
        else $error("supply low warning wrong");
    a_monitor_input_one_low: assert property (
        @(posedge clk) disable iff (sys_rst)
        meas_done[2] |=> chan[2].low == ($past(meas_value[2]) <
            $past(thr_low[2])))
        else $error("monitor one low warning wrong");
    a_monitor_input_two_low: assert property (
        @(posedge clk) disable iff (sys_rst)
        meas_done[3] |=> chan[3].low == ($past(meas_value[3]) <
            $past(thr_low[3])))
        else $error("monitor two low warning wrong");
    a_monitor_input_three_low: assert property (
        @(posedge clk) disable iff (sys_rst)
        meas_done[4] |=> chan[4].low == ($past(meas_value[4]) <
            $past(thr_low[4])))
        else $error("monitor three low warning wrong");
    a_monitor_input_four_low: assert property (
        @(posedge clk) disable iff (sys_rst)
        meas_done[5] |=> chan[5].low == ($past(meas_value[5]) <
            $past(thr_low[5])))
        else $error("monitor four low warning wrong");
    a_temperature_high_flag_keep: assert property (
        @(posedge clk) disable iff (sys_rst)
        !meas_done[0] |=> $stable(chan[0].high))
        else $error("temperature high warning moved");
    a_supply_hi_keep: assert property (
        @(posedge clk) disable iff (sys_rst)
        !meas_done[1] |=> $stable(chan[1].high))
        else $error("supply high warning moved");
    a_monitor_input_one_hi_keep: assert property (
        @(posedge clk) disable iff (sys_rst)
        !meas_done[2] |=> $stable(chan[2].high))
        else $error("monitor one high warning moved");
    a_monitor_input_two_hi_keep: assert property (
        @(posedge clk) disable iff (sys_rst)
        !meas_done[3] |=> $stable(chan[3].high))
        else $error("monitor two high warning moved");
    a_monitor_input_three_hi_keep: assert property (
        @(posedge clk) disable iff (sys_rst)
        !meas_done[4] |=> $stable(chan[4].high))
        else $error("monitor three high warning moved");
    a_monitor_input_four_hi_keep: assert property (
        @(posedge clk) disable iff (sys_rst)
        !meas_done[5] |=> $stable(chan[5].high))
        else $error("monitor four high warning moved");
    a_read_fast: assert property (
        @(posedge clk) disable iff (sys_rst)
        (rd_addr == 8'h73) |=> rd_data == $past(fast_alarm_status))
        else $error("fast alarm read wrong");
    a_read_main: assert property (
        @(posedge clk) disable iff (sys_rst)
        (rd_addr == 8'h74) |=> rd_data == $past(warning_status_main))
        else $error("main warning read wrong");
    a_read_aux: assert property (
        @(posedge clk) disable iff (sys_rst)
        (rd_addr == 8'h75) |=> rd_data == $past(warning_status_aux))
        else $error("aux warning read wrong");
    a_unmapped_miss: assert property (
        @(posedge clk) disable iff (sys_rst)
        (rd_addr < 8'h73 || rd_addr > 8'h7A) |=> !rd_hit && rd_data == 8'h00)
        else $error("unmapped read not empty");
    a_mapped_hit: assert property (
        @(posedge clk) disable iff (sys_rst)
        (rd_addr >= 8'h73 && rd_addr <= 8'h75) |=> rd_hit)
        else $error("flag register read missed");
    a_write_aux_kept: assert property (
        @(posedge clk) disable iff (sys_rst)
        (wr_en && meas_done == 6'h00) |=> $stable(warning_status_aux))
        else $error("host write altered aux warnings");
    a_write_main_kept: assert property (
        @(posedge clk) disable iff (sys_rst)
        (wr_en && meas_done == 6'h00 && !st_q.below_trip)
        |=> $stable(warning_status_main))
        else $error("host write altered main warnings");
    a_write_fast_kept: assert property (
        @(posedge clk) disable iff (sys_rst)
        (wr_en && !fast_cmp_done) |=> $stable(st_q.m3_fast_lo))
        else $error("host write altered fast low alarm");
    a_trip_agree: assert property (
        @(posedge clk) disable iff (sys_rst)
        (st_q.trip_sync[2] == st_q.trip_sync[1])
        |=> st_q.below_trip == $past(st_q.trip_sync[2]))
        else $error("trip level not taken on agreement");
    a_trip_hold: assert property (
        @(posedge clk) disable iff (sys_rst)
        (st_q.trip_sync[2] != st_q.trip_sync[1]) |=> $stable(st_q.below_trip))
        else $error("trip level taken without agreement");
endmodule

// ---- sim/mawf_host_model.sv ----
/*
 * host on the serial memory map: reads and writes flag bank bytes.
 * assumes: same clock as the bank; read data lands one edge after the
 * edge that drives the address.
 */
`timescale 1ns/1ps
`include "mawf_consts.svh"
module mawf_host_model (
    input wire logic clk,
    output logic [`MAWF_ADDR_W-1:0] rd_addr,
    input wire mawf_pkg::mawf_byte_t rd_data,
    input wire logic rd_hit,
    output logic wr_en,
    output logic [`MAWF_ADDR_W-1:0] wr_addr,
    output mawf_pkg::mawf_byte_t wr_data
);
    initial begin
        rd_addr = 8'h00;
        wr_en = 1'b0;
        wr_addr = 8'h00;
        wr_data = 8'h00;
    end
    task automatic rd(input logic [7:0] a, output mawf_pkg::mawf_byte_t d,
                      output logic h);
        @(posedge clk);
        rd_addr <= a;
        @(posedge clk);
        #1;
        d = rd_data;
        h = rd_hit;
    endtask
    // write then scramble the lines so no stale value lingers
    task automatic wr(input logic [7:0] a, input mawf_pkg::mawf_byte_t d);
        @(posedge clk);
        wr_en <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        wr_addr <= ~a;
        wr_data <= ~d;
    endtask
endmodule

// ---- sim/test_monitor_alarm_warning_flags.sv ----
/*
 * self-checking bench of the flag bank against a behavioural model.
 * assumes: mawf_host_model drives the memory map side.
 */
`timescale 1ns/1ps
`include "mawf_consts.svh"
module test_monitor_alarm_warning_flags;
    logic clk, sys_rst, rd_hit, wr_en, fast_cmp_done, fast_above, fast_below;
    logic tx_disable_event, power_on_analog_trip;
    logic [`MAWF_ADDR_W-1:0] rd_addr, wr_addr;
    mawf_pkg::mawf_byte_t rd_data, wr_data;
    logic [8:0] bias_request, bias_ceiling_limit;
    mawf_pkg::mawf_meas_t meas_value [6], thr_high [6], thr_low [6];
    logic [5:0] meas_done;
    int fail_count, checks;
    // model: main warnings in 11:4, aux warnings in 3:0
    logic [11:0] m_warn;
    logic [1:0] m_fast;
    mawf_flag_bank uut (.clk(clk), .sys_rst(sys_rst), .rd_addr(rd_addr),
        .rd_data(rd_data), .rd_hit(rd_hit), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .fast_cmp_done(fast_cmp_done),
        .fast_above(fast_above), .fast_below(fast_below),
        .bias_request(bias_request), .bias_ceiling_limit(bias_ceiling_limit),
        .tx_disable_event(tx_disable_event),
        .power_on_analog_trip(power_on_analog_trip), .meas_value(meas_value),
        .thr_high(thr_high), .thr_low(thr_low), .meas_done(meas_done));
    mawf_host_model host (.clk(clk), .rd_addr(rd_addr), .rd_data(rd_data),
        .rd_hit(rd_hit), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));
    task automatic chk(input mawf_pkg::mawf_byte_t seen, input mawf_pkg::mawf_byte_t exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    function automatic logic bias_exp();
        return !tx_disable_event && (bias_request > bias_ceiling_limit);
    endfunction
    task automatic rc(input logic [7:0] a, input mawf_pkg::mawf_byte_t e);
        mawf_pkg::mawf_byte_t d;
        logic h;
        host.rd(a, d, h);
        chk(d, e);
        chk({7'h00, h}, {7'h00, a >= 8'h73 && a <= 8'h7A});
    endtask
    task automatic meas(input logic [5:0] m, input logic f);
        @(posedge clk);
        meas_done <= m;
        fast_cmp_done <= f;
        @(posedge clk);
        meas_done <= 6'h00;
        fast_cmp_done <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            if (m[i]) begin
                m_warn[11-2*i] = meas_value[i] > thr_high[i];
                m_warn[10-2*i] = meas_value[i] < thr_low[i];
            end
        end
        if (power_on_analog_trip)
            m_warn[8] = 1'b1;
        if (f)
            m_fast = {fast_above, fast_below};
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #200000;
        fail_count++;
        close_out();
    end
    initial begin
        int k, r;
        logic [15:0] th, tl;
        {sys_rst, fast_cmp_done, fast_above, fast_below} = 4'h8;
        {tx_disable_event, power_on_analog_trip, meas_done} = 8'h00;
        {bias_request, bias_ceiling_limit} = 18'h00000;
        for (int i = 0; i < 6; i++)
            {meas_value[i], thr_high[i], thr_low[i]} = 48'h0;
        fail_count = 0;
        checks = 0;
        // supply low warning powers up set: main bit 4 is m_warn[8]
        m_warn = 12'h100;
        m_fast = 2'h0;
        r = $urandom(40);
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        for (int a = 8'h72; a <= 8'h7B; a++)
            rc(8'(a), a == 8'h74 ? 8'h10 : 8'h00);
        repeat (40) begin
            @(posedge clk);
            for (int i = 0; i < 6; i++) begin
                k = $urandom % 4;
                th = 16'($urandom);
                tl = 16'($urandom);
                thr_high[i] <= th;
                thr_low[i] <= tl;
                meas_value[i] <= k == 0 ? th : k == 1 ? tl : 16'($urandom);
            end
            r = $urandom % 3;
            fast_above <= r == 1;
            fast_below <= r == 2;
            th = 16'($urandom);
            bias_ceiling_limit <= th[8:0];
            bias_request <= r == 0 ? th[8:0] : 9'($urandom);
            tx_disable_event <= ($urandom % 4) == 0;
            meas(6'h3F, 1'b1);
            host.wr(8'h73 + 8'($urandom % 8), 8'($urandom));
            rc(8'h73, {m_fast, 2'h0, bias_exp(), 3'h0});
            rc(8'h74, m_warn[11:4]);
            rc(8'h75, {m_warn[3:0], 4'h0});
            rc(8'h76 + 8'($urandom % 5), 8'h00);
        end
        @(posedge clk);
        power_on_analog_trip <= 1'b1;
        meas_value[1] <= 16'h8000;
        thr_low[1] <= 16'h1000;
        thr_high[1] <= 16'hF000;
        repeat (6) @(posedge clk);
        m_warn[8] = 1'b1;
        rc(8'h74, m_warn[11:4]);
        meas(6'h02, 1'b0);
        rc(8'h74, m_warn[11:4]);
        @(posedge clk);
        power_on_analog_trip <= 1'b0;
        repeat (6) @(posedge clk);
        rc(8'h74, m_warn[11:4]);
        meas(6'h02, 1'b0);
        rc(8'h74, m_warn[11:4]);
        @(posedge clk);
        sys_rst <= 1'b1;
        bias_request <= 9'h000;
        @(posedge clk);
        sys_rst <= 1'b0;
        rc(8'h74, 8'h10);
        rc(8'h73, 8'h00);
        close_out();
    end
endmodule
